// file: design/shs_settle_timer.sv
/*
 * oscillation settle timer: counts a loaded number of clocks, then pulses done.
 * assumes start is a one-cycle pulse and count is at least one.
 */
`timescale 1ns/1ps
module shs_settle_timer (
  input  wire logic   clock,
  input  wire logic   rst,
  shs_settle_if.tmr   tif
);

  logic [17:0] left_q;
  logic        busy_q;
  logic        done_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      left_q <= 18'h00000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tif.start) begin
        left_q <= tif.count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (left_q == 18'h00001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        left_q <= left_q - 18'h00001;
      end
    end
  end

  assign tif.busy = busy_q;
  assign tif.done = done_q;

  a_settle_len: assert property (@(posedge clock) disable iff (rst)
    tif.start && tif.count == shs_pkg::SHS_CYC_2P7 |-> ##129 tif.done)
    else $error("settle done not after loaded count");

endmodule

// file: design/shs_standby_ctrl.sv
/*
 * standby controller: idle (cpu clock gated) and oscillator stop modes,
 * their release by interrupt, nmi or reset request, the settle wait,
 * peripheral run enables and a small register port.
 * assumes the core gives one-cycle instruction pulses and holds
 * its flags steady as levels; all inputs are synchronous to clock.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - idle instruction puts the device into idle mode.
// - idle gates cpu clock; timers, wdt, serial, interrupts run; adc, multiplier stop.
// - port latches hold their values throughout idle.
// - unmasked interrupt ends idle; enable picks vector or next instruction.
// - idle release waits 9 clocks to vector, 1 clock to resume.
// - nmi ends idle and vectors regardless of accept enable.
// - reset request in idle ends it like an ordinary reset.
// - stop instruction enters oscillator stop mode; oscillator halts.
// - pending unmasked request at entry releases standby at once.
// - stop with pending request goes idle-like, waits settle time, then runs.
// - stop halts timer16, wdt, adc, multiplier; timer8 only on external pin.
// - serial keeps running in stop while externally clocked.
// - port latches hold their values throughout stop.
// - only unmasked interrupt or reset request release stop.
// - interrupt release of stop waits settle time, then vectors or resumes.
// - rc variant settles for 2^7 clocks.
// - settle select 000/010/100 give 2^12/2^15/2^17; reset value 04h.
// - reset release of stop asserts core_reset at once and holds it through the settle wait.
module shs_standby_ctrl #(
  parameter int SETTLE_2P15 = shs_pkg::SHS_CYC_2P15,
  parameter int SETTLE_2P17 = shs_pkg::SHS_CYC_2P17
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic        exec_idle,
  input  wire logic        exec_stop,
  input  wire logic [7:0]  irq_req,
  input  wire logic [7:0]  irq_mask_flag,
  input  wire logic        irq_accept_enable,
  input  wire logic        nmi_req,
  input  wire logic        reset_req,
  input  wire logic        timer8_ext_count_pin,
  input  wire logic        serial_ext_clk,
  output logic             cpu_clk_en,
  output logic             osc_run,
  output logic             port_latch_hold,
  output logic             timer16_en,
  output logic             timer8_en,
  output logic             wdt_en,
  output logic             serial_en,
  output logic             adc_en,
  output logic             mult_en,
  output logic             core_reset,
  output logic             resume_next,
  output logic             vector_take
);

  shs_settle_if          sif ();
  shs_pkg::shs_state_t   st_q;
  shs_pkg::shs_state_t   st_d;
  logic [2:0]            osc_settle_select_q;
  logic                  rc_variant_q;
  logic                  wake;
  logic                  vec_q;
  logic [3:0]            wait_q;
  logic                  osc_d;
  logic                  idle_like_d;
  logic [7:0]            rdata_q;

  // prohibited codes fall back to the longest wait, the safe side
  function automatic logic [17:0] settle_cycles(input logic [2:0] sel,
                                                input logic       rc);
    logic [17:0] c;
    c = SETTLE_2P17[17:0];
    if (rc)
      c = shs_pkg::SHS_CYC_2P7;
    else if (sel == shs_pkg::SHS_SEL_2P12)
      c = shs_pkg::SHS_CYC_2P12;
    else if (sel == shs_pkg::SHS_SEL_2P15)
      c = SETTLE_2P15[17:0];
    return c;
  endfunction

  assign wake = |(irq_req & ~irq_mask_flag);

  always_comb begin
    st_d = st_q;
    case (st_q)
      shs_pkg::SHS_ST_RUN: begin
        if (reset_req)
          st_d = shs_pkg::SHS_ST_RESET;
        else if (exec_stop)
          st_d = wake ? shs_pkg::SHS_ST_SETTLE : shs_pkg::SHS_ST_STOP;
        else if (exec_idle)
          st_d = wake ? shs_pkg::SHS_ST_WAIT : shs_pkg::SHS_ST_IDLE;
      end
      shs_pkg::SHS_ST_IDLE: begin
        if (reset_req)
          st_d = shs_pkg::SHS_ST_RESET;
        else if (nmi_req || wake)
          st_d = shs_pkg::SHS_ST_WAIT;
      end
      shs_pkg::SHS_ST_STOP: begin
        if (reset_req)
          st_d = shs_pkg::SHS_ST_RSTW;
        else if (wake)
          st_d = shs_pkg::SHS_ST_SETTLE;
      end
      shs_pkg::SHS_ST_SETTLE: begin
        if (sif.done)
          st_d = shs_pkg::SHS_ST_RUN;
      end
      // the short wake wait runs out before a reset request is served
      shs_pkg::SHS_ST_WAIT: begin
        if (wait_q == 4'h1)
          st_d = shs_pkg::SHS_ST_RUN;
      end
      shs_pkg::SHS_ST_RSTW: begin
        if (sif.done)
          st_d = shs_pkg::SHS_ST_RESET;
      end
      shs_pkg::SHS_ST_RESET: begin
        if (!reset_req)
          st_d = shs_pkg::SHS_ST_RUN;
      end
      default: st_d = shs_pkg::SHS_ST_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst)
      st_q <= shs_pkg::SHS_ST_RUN;
    else
      st_q <= st_d;
  end

  // release kind, captured as the wait begins
  always_ff @(posedge clock) begin
    if (rst) begin
      vec_q  <= 1'b0;
      wait_q <= 4'h0;
    end else if (st_d == shs_pkg::SHS_ST_WAIT && st_q != shs_pkg::SHS_ST_WAIT) begin
      vec_q  <= (st_q == shs_pkg::SHS_ST_IDLE && nmi_req) || irq_accept_enable;
      wait_q <= ((st_q == shs_pkg::SHS_ST_IDLE && nmi_req) || irq_accept_enable)
                ? shs_pkg::SHS_WAIT_VEC : shs_pkg::SHS_WAIT_NEXT;
    end else if (st_d == shs_pkg::SHS_ST_SETTLE && st_q != shs_pkg::SHS_ST_SETTLE) begin
      vec_q  <= irq_accept_enable;
    end else if (st_q == shs_pkg::SHS_ST_WAIT) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  assign sif.start = (st_d == shs_pkg::SHS_ST_SETTLE && st_q != shs_pkg::SHS_ST_SETTLE) ||
                     (st_d == shs_pkg::SHS_ST_RSTW && st_q != shs_pkg::SHS_ST_RSTW);
  assign sif.count = settle_cycles(osc_settle_select_q, rc_variant_q);

  shs_settle_timer u_settle (
    .clock (clock),
    .rst   (rst),
    .tif   (sif)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      resume_next <= 1'b0;
      vector_take <= 1'b0;
    end else begin
      resume_next <= 1'b0;
      vector_take <= 1'b0;
      if (st_d == shs_pkg::SHS_ST_RUN &&
          (st_q == shs_pkg::SHS_ST_WAIT || st_q == shs_pkg::SHS_ST_SETTLE)) begin
        vector_take <= vec_q;
        resume_next <= !vec_q;
      end
    end
  end

  assign osc_d = st_d != shs_pkg::SHS_ST_STOP;
  assign idle_like_d = st_d == shs_pkg::SHS_ST_IDLE || st_d == shs_pkg::SHS_ST_WAIT ||
                       st_d == shs_pkg::SHS_ST_SETTLE;

  // run enables follow the next state so they line up with st_q
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_clk_en      <= 1'b1;
      osc_run         <= 1'b1;
      port_latch_hold <= 1'b0;
      timer16_en      <= 1'b1;
      timer8_en       <= 1'b1;
      wdt_en          <= 1'b1;
      serial_en       <= 1'b1;
      adc_en          <= 1'b1;
      mult_en         <= 1'b1;
      core_reset      <= 1'b0;
    end else begin
      cpu_clk_en      <= st_d == shs_pkg::SHS_ST_RUN;
      osc_run         <= osc_d;
      port_latch_hold <= idle_like_d || !osc_d;
      timer16_en      <= osc_d;
      timer8_en       <= osc_d || timer8_ext_count_pin;
      wdt_en          <= osc_d;
      serial_en       <= osc_d || serial_ext_clk;
      adc_en          <= st_d == shs_pkg::SHS_ST_RUN;
      mult_en         <= st_d == shs_pkg::SHS_ST_RUN;
      core_reset      <= st_d == shs_pkg::SHS_ST_RESET || st_d == shs_pkg::SHS_ST_RSTW;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_settle_select_q <= shs_pkg::SHS_SETTLE_RST;
      rc_variant_q        <= 1'b0;
    end else if (reg_we) begin
      if (reg_addr == shs_pkg::SHS_OFF_SETTLE)
        osc_settle_select_q <= reg_wdata[2:0];
      if (reg_addr == shs_pkg::SHS_OFF_CTRL)
        rc_variant_q <= reg_wdata[shs_pkg::SHS_CTRL_RC_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_re) begin
      case (reg_addr)
        shs_pkg::SHS_OFF_SETTLE: rdata_q <= {5'h00, osc_settle_select_q};
        shs_pkg::SHS_OFF_CTRL:   rdata_q <= {7'h00, rc_variant_q};
        shs_pkg::SHS_OFF_STATUS: rdata_q <= {3'h0, sif.busy, wake, st_q};
        default:                 rdata_q <= 8'h00;
      endcase
    end else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  a_idle_entry: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_RUN && exec_idle && !exec_stop && !wake && !reset_req
    |=> st_q == shs_pkg::SHS_ST_IDLE && !cpu_clk_en)
    else $error("idle not entered");

  a_idle_gating: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE |-> !cpu_clk_en && osc_run && timer16_en && wdt_en
      && serial_en && !adc_en && !mult_en)
    else $error("idle run enables wrong");

  a_idle_hold: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE |-> port_latch_hold)
    else $error("ports not held in idle");

  a_idle_masked: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE && !wake && !nmi_req && !reset_req
    |=> st_q == shs_pkg::SHS_ST_IDLE)
    else $error("idle left without cause");

  a_vec_wait: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE && wake && irq_accept_enable && !reset_req
    |=> (st_q == shs_pkg::SHS_ST_WAIT)[*8] ##1 st_q == shs_pkg::SHS_ST_WAIT
    ##1 vector_take && cpu_clk_en)
    else $error("vectored wake wait not 9 clocks");

  a_next_wait: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE && wake && !nmi_req && !irq_accept_enable && !reset_req
    |=> st_q == shs_pkg::SHS_ST_WAIT ##1 resume_next && !vector_take)
    else $error("plain wake wait not 1 clock");

  a_nmi_vector: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE && nmi_req && !reset_req
    |=> vec_q ##9 vector_take)
    else $error("nmi did not vector");

  a_idle_reset: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE && reset_req |=> core_reset)
    else $error("reset in idle ignored");

  a_stop_osc: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_STOP |-> !osc_run && port_latch_hold)
    else $error("oscillator runs in stop");

  a_stop_instant: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_RUN && exec_stop && wake && !reset_req
    |=> st_q == shs_pkg::SHS_ST_SETTLE && osc_run && !cpu_clk_en)
    else $error("stop with pending wake did not settle");

  a_stop_periph: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_STOP |-> !timer16_en && !wdt_en && !adc_en
      && timer8_en == $past(timer8_ext_count_pin) && serial_en == $past(serial_ext_clk))
    else $error("stop run enables wrong");

  a_stop_stays: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_STOP && !wake && !reset_req |=> st_q == shs_pkg::SHS_ST_STOP)
    else $error("stop left without cause");

  a_stop_reset: assert property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_STOP && reset_req
    |=> st_q == shs_pkg::SHS_ST_RSTW && core_reset && osc_run)
    else $error("reset release of stop skipped settle");

  c_idle_vector: cover property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_IDLE ##1 st_q == shs_pkg::SHS_ST_WAIT ##[1:12] vector_take);
  c_stop_wake: cover property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_STOP ##1 st_q == shs_pkg::SHS_ST_SETTLE);
  c_stop_reset: cover property (@(posedge clock) disable iff (rst)
    st_q == shs_pkg::SHS_ST_RSTW ##1 st_q == shs_pkg::SHS_ST_RESET);

endmodule

// file: include/shs_pkg.sv
/*
 * shared constants and types of the standby controller: register offsets,
 * reset values, settle codes and counts, wake wait lengths and the state code.
 * assumes nothing of its surroundings; the files that use it name it in full.
 */
package shs_pkg;

  localparam int          SHS_ADDR_W      = 4;
  localparam int          SHS_DATA_W      = 8;
  localparam int          SHS_IRQ_N       = 8;
  localparam int          SHS_CNT_W       = 18;

  localparam logic [3:0]  SHS_OFF_SETTLE  = 4'h0;
  localparam logic [3:0]  SHS_OFF_CTRL    = 4'h1;
  localparam logic [3:0]  SHS_OFF_STATUS  = 4'h2;

  localparam logic [2:0]  SHS_SETTLE_RST  = 3'h4;
  localparam logic [2:0]  SHS_SEL_2P12    = 3'h0;
  localparam logic [2:0]  SHS_SEL_2P15    = 3'h2;
  localparam logic [2:0]  SHS_SEL_2P17    = 3'h4;
  localparam int          SHS_CTRL_RC_BIT = 0;

  // settle lengths in clock cycles (one crystal or rc cycle per clock)
  localparam logic [17:0] SHS_CYC_2P7     = 18'h00080;
  localparam logic [17:0] SHS_CYC_2P12    = 18'h01000;
  localparam int          SHS_CYC_2P15    = 32768;
  localparam int          SHS_CYC_2P17    = 131072;

  localparam logic [3:0]  SHS_WAIT_VEC    = 4'h9;
  localparam logic [3:0]  SHS_WAIT_NEXT   = 4'h1;

  typedef enum logic [2:0] {
    SHS_ST_RUN    = 3'b000,
    SHS_ST_IDLE   = 3'b001,
    SHS_ST_STOP   = 3'b010,
    SHS_ST_SETTLE = 3'b011,
    SHS_ST_WAIT   = 3'b100,
    SHS_ST_RSTW   = 3'b101,
    SHS_ST_RESET  = 3'b110
  } shs_state_t;

endpackage

// file: include/shs_settle_if.sv
/*
 * carrier between the standby controller and its settle timer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface shs_settle_if;
  logic        start;
  logic [17:0] count;
  logic        busy;
  logic        done;
  modport ctrl (output start, output count, input busy, input done);
  modport tmr  (input start, input count, output busy, output done);
endinterface

// file: sim/shs_core_model.sv
/*
 * behavioural model of the core's interrupt controller: request and nmi
 * flags set by the bench, cleared when the controller vectors to them.
 * assumes the same clock as the standby controller and a level flag set.
 */
`timescale 1ns/1ps
module shs_core_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] irq_set,
  input  wire logic       nmi_set,
  input  wire logic       flags_clr,
  input  wire logic [7:0] irq_mask_flag,
  input  wire logic       vector_take,
  output logic      [7:0] irq_req,
  output logic            nmi_req
);
  logic [7:0] live;
  logic [7:0] pick;

  assign live = irq_req & ~irq_mask_flag;
  // lowest unmasked source is serviced; nmi goes first
  assign pick = live & ~(live - 8'h01);

  always_ff @(posedge clock) begin
    if (rst || flags_clr) begin
      irq_req <= 8'h00;
      nmi_req <= 1'b0;
    end else begin
      irq_req <= (irq_req | irq_set) & ~((vector_take && !nmi_req) ? pick : 8'h00);
      nmi_req <= (nmi_req | nmi_set) & ~vector_take;
    end
  end
endmodule

// file: sim/shs_standby_ctrl_tb.sv
/*
 * self-checking bench for the standby controller with a core model.
 * assumes shortened settle parameters and the package register map.
 */
`timescale 1ns/1ps
module shs_standby_ctrl_tb;
  typedef struct {
    logic       stop;
    logic       ie;
    logic       nmi;
    logic [2:0] sel;
    logic       rc;
    logic       pin;
    logic       eclk;
    int         lo;
    int         hi;
    logic       vec;
  } shs_row_t;

  localparam int P15 = 40;
  localparam int P17 = 60;

  logic       clock         = 1'b0;
  logic       rst           = 1'b1;
  logic [3:0] reg_addr      = 4'h0;
  logic [7:0] reg_wdata     = 8'h00;
  logic       reg_we        = 1'b0;
  logic       reg_re        = 1'b0;
  logic       exec_idle     = 1'b0;
  logic       exec_stop     = 1'b0;
  logic [7:0] irq_set       = 8'h00;
  logic       nmi_set       = 1'b0;
  logic       flags_clr     = 1'b0;
  logic [7:0] irq_mask_flag = 8'hff;
  logic       ie            = 1'b0;
  logic       reset_req     = 1'b0;
  logic       pin           = 1'b0;
  logic       eclk          = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] irq_req;
  logic       nmi_req;
  logic       core_reset;
  logic       resume_next;
  logic       vector_take;
  wire  [8:0] en;
  int         fail_count    = 0;
  int         checks        = 0;
  // wake windows start one clock past each documented wait and reach 4 (idle) or 6 (stop) clocks beyond it
  shs_row_t   rows [8] = '{
    '{1'b0, 1'b1, 1'b0, 3'h4, 1'b0, 1'b1, 1'b1, 10, 13, 1'b1},
    '{1'b0, 1'b0, 1'b0, 3'h4, 1'b0, 1'b1, 1'b1, 2, 5, 1'b0},
    '{1'b0, 1'b0, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0, 10, 13, 1'b1},
    '{1'b1, 1'b1, 1'b1, 3'h4, 1'b0, 1'b1, 1'b0, P17 + 1, P17 + 6, 1'b1},
    '{1'b1, 1'b0, 1'b0, 3'h2, 1'b0, 1'b0, 1'b1, P15 + 1, P15 + 6, 1'b0},
    '{1'b1, 1'b1, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 4097, 4102, 1'b1},
    '{1'b1, 1'b0, 1'b0, 3'h7, 1'b0, 1'b0, 1'b0, P17 + 1, P17 + 6, 1'b0},
    '{1'b1, 1'b1, 1'b0, 3'h2, 1'b1, 1'b0, 1'b0, 129, 134, 1'b1}};

  always #5 clock = ~clock;

  shs_standby_ctrl #(.SETTLE_2P15(P15), .SETTLE_2P17(P17)) u_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .exec_idle(exec_idle),
    .exec_stop(exec_stop), .irq_req(irq_req), .irq_mask_flag(irq_mask_flag),
    .irq_accept_enable(ie), .nmi_req(nmi_req), .reset_req(reset_req),
    .timer8_ext_count_pin(pin), .serial_ext_clk(eclk), .cpu_clk_en(en[8]),
    .osc_run(en[7]), .port_latch_hold(en[6]), .timer16_en(en[5]), .timer8_en(en[4]),
    .wdt_en(en[3]), .serial_en(en[2]), .adc_en(en[1]), .mult_en(en[0]),
    .core_reset(core_reset), .resume_next(resume_next), .vector_take(vector_take));

  shs_core_model u_core (
    .clock(clock), .rst(rst), .irq_set(irq_set), .nmi_set(nmi_set),
    .flags_clr(flags_clr), .irq_mask_flag(irq_mask_flag), .vector_take(vector_take),
    .irq_req(irq_req), .nmi_req(nmi_req));

  task automatic finish_test();
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // one-cycle strobes towards the core model
  task automatic sig(input logic [7:0] b, input logic n, input logic c);
    @(posedge clock);
    irq_set <= b;
    nmi_set <= n;
    flags_clr <= c;
    @(posedge clock);
    irq_set <= 8'h00;
    nmi_set <= 1'b0;
    flags_clr <= 1'b0;
  endtask

  task automatic enter(input logic stop);
    @(posedge clock);
    exec_stop <= stop;
    exec_idle <= !stop;
    @(posedge clock);
    exec_stop <= 1'b0;
    exec_idle <= 1'b0;
  endtask

  task automatic bound(input int n, input int lo, input int hi);
    if (n >= 5000) begin
      fail_count++;
      $display("CHECK FAILED %0t no response in time", $time);
      finish_test();
    end else begin
      chk(16'(n >= lo && n <= hi), 16'h0001);
    end
  endtask

  task automatic wait_pulse(input int lo, input int hi, input logic vec);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (vector_take !== 1'b1 && resume_next !== 1'b1 && n < 5000);
    bound(n, lo, hi);
    chk({14'h0, vector_take, resume_next}, {14'h0, vec, !vec});
  endtask

  initial begin
    int n;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    tick(1);
    chk({4'h0, core_reset, vector_take, resume_next, en}, 16'h01bf);
    rd(4'h0, 8'h04);
    rd(4'h1, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h00);
    rd(4'hf, 8'h00);
    foreach (rows[i]) begin
      wr(4'h0, {5'h00, rows[i].sel});
      wr(4'h1, {7'h00, rows[i].rc});
      rd(4'h0, {5'h00, rows[i].sel});
      @(posedge clock);
      ie <= rows[i].ie;
      pin <= rows[i].pin;
      eclk <= rows[i].eclk;
      irq_mask_flag <= ~(8'h01 << i);
      // a masked pending source must not wake anything
      sig(8'h01 << ((i + 1) % 8), 1'b0, 1'b0);
      enter(rows[i].stop);
      tick(2);
      chk({7'h00, en}, rows[i].stop ? {7'h00, 4'h2, rows[i].pin, 1'b0, rows[i].eclk, 2'b00}
                                    : 16'h00fc);
      if (rows[i].nmi) sig(8'h00, 1'b1, 1'b0);
      if (rows[i].stop && rows[i].nmi) begin
        tick(8);
        chk({14'h0, en[8:7]}, 16'h0000);
      end
      if (rows[i].stop || !rows[i].nmi) sig(8'h01 << i, 1'b0, 1'b0);
      wait_pulse(rows[i].lo, rows[i].hi, rows[i].vec);
      tick(1);
      chk({5'h00, vector_take, resume_next, en}, 16'h01bf);
      sig(8'h00, 1'b0, 1'b1);
    end
    // pending unmasked request at entry: idle falls straight through
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h00);
    @(posedge clock);
    ie <= 1'b0;
    irq_mask_flag <= 8'hfe;
    sig(8'h01, 1'b0, 1'b0);
    enter(1'b0);
    wait_pulse(1, 5, 1'b0);
    enter(1'b1);
    tick(2);
    chk({15'h0, en[7]}, 16'h0001);
    wait_pulse(P17 - 2, P17 + 5, 1'b0);
    sig(8'h00, 1'b0, 1'b1);
    // masked request holds idle; only the reset request ends it
    @(posedge clock);
    irq_mask_flag <= 8'hff;
    ie <= 1'b1;
    sig(8'h10, 1'b0, 1'b0);
    enter(1'b0);
    tick(20);
    chk({7'h00, en}, 16'h00fc);
    @(posedge clock);
    reset_req <= 1'b1;
    tick(3);
    chk({15'h0, core_reset}, 16'h0001);
    @(posedge clock);
    reset_req <= 1'b0;
    tick(3);
    chk({6'h00, core_reset, en}, 16'h01bf);
    sig(8'h00, 1'b0, 1'b1);
    // reset in stop: settle runs out even if the request drops early
    enter(1'b1);
    sig(8'h00, 1'b1, 1'b0);
    tick(6);
    chk({14'h0, en[8:7]}, 16'h0000);
    @(posedge clock);
    reset_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      reset_req <= (n < 10);
      n++;
      #1;
      if (n == 3) chk({14'h0, core_reset, en[7]}, 16'h0003);
    end while ((n < 3 || core_reset !== 1'b0) && n < 5000);
    bound(n, P17, P17 + 8);
    sig(8'h00, 1'b0, 1'b1);
    finish_test();
  end
endmodule
